//--- design/host_bus_port.sv
`timescale 1ns/1ps
`include "hostbus_defines.svh"

module host_bus_port
  import hostbus_pkg::*;
#(
  parameter int FIFO_DEPTH = 4,
  parameter int CSR_WORDS  = 32
)
(
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic [31:0] ad_in,
  output logic      [31:0] ad_out,
  output logic             ad_oe,
  input  wire logic [3:0]  cbe_l_in,
  output logic      [3:0]  cbe_l_out,
  output logic             cbe_oe,
  input  wire logic        par_in,
  output logic             par_out,
  output logic             par_oe,
  input  wire logic        frame_l_in,
  output logic             frame_l_out,
  output logic             frame_oe,
  input  wire logic        irdy_l_in,
  output logic             irdy_l_out,
  output logic             irdy_oe,
  input  wire logic        trdy_l_in,
  output logic             trdy_l_out,
  output logic             trdy_oe,
  input  wire logic        devsel_l_in,
  output logic             devsel_l_out,
  output logic             devsel_oe,
  output logic             stop_l_out,
  output logic             stop_oe,
  input  wire logic        idsel,
  output logic             req_l,
  input  wire logic        gnt_l,
  input  wire logic        rd_start,
  input  wire logic [31:0] rd_addr,
  input  wire logic [7:0]  rd_words,
  output logic             rd_busy,
  output logic             rd_valid,
  input  wire logic        rd_ready,
  output logic      [31:0] rd_data,
  output logic             parity_err
);

  initial
  begin
    if (CSR_WORDS < 2 || CSR_WORDS > 32) $error("host_bus_port CSR_WORDS out of range");
  end

  // ----------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------
  typedef struct packed {
    bus_state_e  st;
    logic [31:0] addr;
    logic [3:0]  cmd;
    logic        is_cfg;
    logic [31:0] ad_o;
    logic [3:0]  cbe_o;
    logic        ad_en;
    logic        cbe_en;
    logic        par_en;
    logic        frame_o;
    logic        irdy_o;
    logic        trdy_o;
    logic        devsel_o;
    logic        stop_o;
    logic        req_o;
    logic [7:0]  left;
    logic [31:0] mode;
    logic        chk_par;
    logic        par;
    logic        perr;
  } port_s;

  port_s state_r;
  port_s state_nxt;

  logic        claim;
  logic        is_write;
  logic        be_off;
  logic        wr_cfg;
  logic        wr_csr;
  logic [31:0] cfg_q;
  logic [31:0] csr_q;
  logic        fifo_ready;
  logic        push;
  logic        phase_done;
  logic        mode_hit;
  logic        irdy_on;

  // ----------------------------------------------------------------
  // Command decode for target claims
  // ----------------------------------------------------------------
  always_comb
  begin
    unique case (cbe_l_in)
      `CMD_IO_READ, `CMD_IO_WRITE, `CMD_MEM_READ, `CMD_MEM_WRITE,
      `CMD_MEM_READ_MUL, `CMD_MEM_READ_LN, `CMD_MEM_WR_INV:
        claim = 1'b1;
      `CMD_CFG_READ, `CMD_CFG_WRITE:
        claim = idsel;
      default:
        claim = 1'b0;
    endcase
  end

  assign is_write   = state_r.cmd[0];
  assign be_off     = (cbe_l_in == `BE_ALL_OFF);
  assign phase_done = !irdy_l_in && state_r.trdy_o;
  assign wr_cfg     = (state_r.st == T_DATA) && phase_done && is_write && state_r.is_cfg
                      && !be_off;
  assign wr_csr     = (state_r.st == T_DATA) && phase_done && is_write && !state_r.is_cfg
                      && !be_off;
  assign mode_hit   = (state_r.addr[`CSR_ADDR_MSB:`CSR_ADDR_LSB] == '0);
  // Ready only with room in the buffer, so a completed phase is never lost
  assign irdy_on    = state_r.irdy_o && fifo_ready;
  assign push       = (state_r.st == M_DATA || state_r.st == M_END)
                      && !trdy_l_in && irdy_on;

  // ----------------------------------------------------------------
  // Configuration space and control registers
  // ----------------------------------------------------------------
  word_ram #(.WIDTH(32), .DEPTH(`CFG_SPACE_BYTES / 4)) cfg_ram (
    .clk_sys (clk_sys),
    .wr_en   (wr_cfg),
    .wr_addr (state_r.addr[`CFG_ADDR_MSB:`CFG_ADDR_LSB]),
    .wr_data (ad_in),
    .rd_addr (state_r.addr[`CFG_ADDR_MSB:`CFG_ADDR_LSB]),
    .rd_data (cfg_q)
  );

  word_ram #(.WIDTH(32), .DEPTH(CSR_WORDS)) csr_ram (
    .clk_sys (clk_sys),
    .wr_en   (wr_csr),
    .wr_addr (state_r.addr[$clog2(CSR_WORDS)+1:2]),
    .wr_data (ad_in),
    .rd_addr (state_r.addr[$clog2(CSR_WORDS)+1:2]),
    .rd_data (csr_q)
  );

  // Read words go through the FIFO; a full FIFO holds irdy off
  word_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) rd_fifo (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .in_data   (ad_in),
    .out_valid (rd_valid),
    .out_ready (rd_ready),
    .out_data  (rd_data)
  );

  // ----------------------------------------------------------------
  // Bus sequencer, target and initiator
  // ----------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    state_nxt.par_en  = state_r.ad_en;
    state_nxt.par     = ^{ad_in, cbe_l_in};
    state_nxt.chk_par = 1'b0;
    // Parity of the previous cycle is checked whenever frame or irdy was low and this port left AD undriven
    state_nxt.perr    = state_r.chk_par && (state_r.par != par_in);
    unique case (state_r.st)
      T_IDLE:
      begin
        if (!frame_l_in && claim)
        begin
          state_nxt.addr    = ad_in;
          state_nxt.cmd     = cbe_l_in;
          state_nxt.is_cfg  = (cbe_l_in[3:1] == 3'b101);
          state_nxt.st      = T_DECODE;
        end
        else if (rd_start && frame_l_in && irdy_l_in)
        begin
          state_nxt.addr  = rd_addr;
          state_nxt.left  = rd_words;
          state_nxt.req_o = 1'b1;
          state_nxt.st    = M_REQ;
        end
      end
      T_DECODE:
      begin
        state_nxt.devsel_o = 1'b1;
        if (is_write)
        begin
          state_nxt.trdy_o = 1'b1;
          state_nxt.st     = T_DATA;
        end
        else
          state_nxt.st = T_TURN;
      end
      T_TURN:
      begin
        // Byte enables all off reads as zero, otherwise a full word
        state_nxt.ad_o   = (cbe_l_in == `BE_ALL_OFF) ? `ZERO_WORD
                         : (state_r.is_cfg ? cfg_q
                         : (mode_hit ? state_r.mode : csr_q));
        state_nxt.ad_en  = 1'b1;
        state_nxt.trdy_o = 1'b1;
        state_nxt.st     = T_DATA;
      end
      T_DATA:
      begin
        if (phase_done)
        begin
          if (is_write && !be_off && !state_r.is_cfg && mode_hit)
            state_nxt.mode = ad_in;
          state_nxt.trdy_o = 1'b0;
          state_nxt.ad_en  = 1'b0;
          if (!frame_l_in)
          begin
            state_nxt.stop_o = 1'b1;
            state_nxt.st     = T_RETRY;
          end
          else
          begin
            state_nxt.devsel_o = 1'b0;
            state_nxt.st       = T_DONE;
          end
        end
      end
      T_RETRY:
      begin
        // Stop stands until the host drops frame
        if (frame_l_in)
        begin
          state_nxt.stop_o   = 1'b0;
          state_nxt.devsel_o = 1'b0;
          state_nxt.st       = T_DONE;
        end
      end
      T_DONE:
        state_nxt.st = T_IDLE;
      M_REQ:
      begin
        // Start only with grant sampled and the bus idle
        if (!gnt_l && frame_l_in && irdy_l_in)
        begin
          state_nxt.req_o   = 1'b0;
          state_nxt.frame_o = 1'b1;
          state_nxt.ad_o    = state_r.addr;
          state_nxt.ad_en   = 1'b1;
          state_nxt.cbe_o   = (state_r.mode[`RD_MULT_EN_BIT] && state_r.left > 8'h01)
                              ? `CMD_MEM_READ_MUL : `CMD_MEM_READ;
          state_nxt.cbe_en  = 1'b1;
          state_nxt.st      = M_ADDR;
        end
      end
      M_ADDR:
      begin
        // Grant lost now does not stop the transfer
        state_nxt.ad_en  = 1'b0;
        state_nxt.cbe_o  = `BE_ALL_ON;
        state_nxt.irdy_o = 1'b1;
        state_nxt.frame_o = (state_r.left > 8'h01);
        state_nxt.st     = (state_r.left > 8'h01) ? M_DATA : M_END;
      end
      M_DATA:
      begin
        if (push)
        begin
          state_nxt.left = state_r.left - 8'h01;
          if (state_r.left == 8'h02)
          begin
            state_nxt.frame_o = 1'b0;
            state_nxt.st      = M_END;
          end
        end
      end
      M_END:
      begin
        if (push)
        begin
          state_nxt.left   = 8'h00;
          state_nxt.irdy_o = 1'b0;
          state_nxt.cbe_en = 1'b0;
          state_nxt.st     = T_DONE;
        end
      end
    endcase
    // Parity follows one cycle after each driven word
    state_nxt.chk_par = !state_r.ad_en && (!frame_l_in || !irdy_l_in);
  end

  // Synchronous reset, all handshakes idle
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      state_r      <= '0;
      state_r.st   <= T_IDLE;
      state_r.mode <= `MODE_RESET_VAL;
    end
    else
      state_r <= state_nxt;
  end

  // ----------------------------------------------------------------
  // Pin drive, active-low on the wire
  // ----------------------------------------------------------------
  assign ad_out       = state_r.ad_o;
  assign ad_oe        = state_r.ad_en;
  assign cbe_l_out    = state_r.cbe_o;
  assign cbe_oe       = state_r.cbe_en;
  assign par_out      = state_r.par;
  assign par_oe       = state_r.par_en;
  assign frame_l_out  = !state_r.frame_o;
  assign frame_oe     = state_r.frame_o || state_r.irdy_o;
  assign irdy_l_out   = !irdy_on;
  assign irdy_oe      = state_r.frame_o || state_r.irdy_o;
  assign trdy_l_out   = !state_r.trdy_o;
  assign trdy_oe      = state_r.devsel_o;
  assign devsel_l_out = !state_r.devsel_o;
  assign devsel_oe    = state_r.devsel_o;
  assign stop_l_out   = !state_r.stop_o;
  assign stop_oe      = state_r.devsel_o;
  assign req_l        = !state_r.req_o;
  assign rd_busy      = (state_r.st != T_IDLE);
  assign parity_err   = state_r.perr;

endmodule

//--- design/word_fifo.sv
`timescale 1ns/1ps
`include "hostbus_defines.svh"

// Synchronous FIFO with valid/ready on both sides
module word_fifo
  import hostbus_pkg::*;
#(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
)
(
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("word_fifo depth must be a power of two");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } fifo_s;

  fifo_s state_r;
  fifo_s state_nxt;
  logic  push;
  logic  pop;

  // --------------------------------------------------------------
  // Pointer and count update
  // --------------------------------------------------------------
  assign in_ready  = (state_r.cnt != (AW + 1)'(DEPTH));
  assign out_valid = (state_r.cnt != '0);
  assign out_data  = state_r.mem[state_r.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb
  begin
    state_nxt = state_r;
    if (push)
    begin
      state_nxt.mem[state_r.wp] = in_data;
      state_nxt.wp = state_r.wp + 1'b1;
    end
    if (pop)
      state_nxt.rp = state_r.rp + 1'b1;
    if (push && !pop)
      state_nxt.cnt = state_r.cnt + 1'b1;
    else if (pop && !push)
      state_nxt.cnt = state_r.cnt - 1'b1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      state_r <= '0;
    else
      state_r <= state_nxt;
  end

endmodule

//--- design/word_ram.sv
`timescale 1ns/1ps
`include "hostbus_defines.svh"

// Small register-file memory with registered read data
module word_ram
  import hostbus_pkg::*;
#(
  parameter int WIDTH = 32,
  parameter int DEPTH = 64
)
(
  input  wire logic                     clk_sys,
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input  wire logic [WIDTH-1:0]         wr_data,
  input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic      [WIDTH-1:0]         rd_data
);

  initial
  begin
    if (DEPTH < 2) $error("word_ram depth too small");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [WIDTH-1:0]            dout;
  } ram_s;

  ram_s state_r;
  ram_s state_nxt;

  // --------------------------------------------------------------
  // Write and registered read
  // --------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    state_nxt.dout = state_r.mem[rd_addr];
    if (wr_en)
      state_nxt.mem[wr_addr] = wr_data;
  end

  // No reset: contents are undefined until software writes them
  always_ff @(posedge clk_sys)
  begin
    state_r <= state_nxt;
  end

  assign rd_data = state_r.dout;

endmodule

//--- inc/hostbus_defines.svh
`ifndef HOSTBUS_DEFINES_SVH
`define HOSTBUS_DEFINES_SVH

// ----------------------------------------------------------------
// Bus command codes
// ----------------------------------------------------------------
`define CMD_INT_ACK      4'h0
`define CMD_SPECIAL      4'h1
`define CMD_IO_READ      4'h2
`define CMD_IO_WRITE     4'h3
`define CMD_MEM_READ     4'h6
`define CMD_MEM_WRITE    4'h7
`define CMD_CFG_READ     4'hA
`define CMD_CFG_WRITE    4'hB
`define CMD_MEM_READ_MUL 4'hC
`define CMD_DUAL_ADDR    4'hD
`define CMD_MEM_READ_LN  4'hE
`define CMD_MEM_WR_INV   4'hF

// ----------------------------------------------------------------
// Byte enables and fields
// ----------------------------------------------------------------
`define BE_ALL_ON        4'h0
`define BE_ALL_OFF       4'hF
`define RD_MULT_EN_BIT   21
`define CFG_SPACE_BYTES  256
`define CFG_ADDR_LSB     2
`define CFG_ADDR_MSB     7
`define CSR_ADDR_LSB     2
`define CSR_ADDR_MSB     6
`define ZERO_WORD        32'h0000_0000
`define MODE_RESET_VAL   32'h0000_0000

`endif

//--- inc/hostbus_pkg.sv
package hostbus_pkg;

  typedef enum logic [3:0] {
    T_IDLE,
    T_DECODE,
    T_TURN,
    T_DATA,
    T_RETRY,
    T_DONE,
    M_REQ,
    M_ADDR,
    M_DATA,
    M_END
  } bus_state_e;

endpackage

//--- test/host_bus_port_sva.sv
`timescale 1ns/1ps
// Pin-level protocol watch on the host bus port
module host_bus_port_sva
(
  input wire logic       clk_sys,
  input wire logic       reset,
  input wire logic       ad_oe,
  input wire logic [3:0] cbe_l_in,
  input wire logic [3:0] cbe_l_out,
  input wire logic       cbe_oe,
  input wire logic       frame_l_in,
  input wire logic       frame_l_out,
  input wire logic       frame_oe,
  input wire logic       irdy_l_out,
  input wire logic       irdy_oe,
  input wire logic       trdy_l_in,
  input wire logic       trdy_l_out,
  input wire logic       devsel_l_out,
  input wire logic       devsel_oe,
  input wire logic       idsel,
  input wire logic       req_l,
  input wire logic       gnt_l
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  // Master start: grant seen on the launching edge, request dropped with it
  a_frame_on_grant: assert property (
    frame_oe && $fell(frame_l_out) |-> !$past(gnt_l))
    else $error("frame started without grant");
  a_req_with_frame: assert property (
    frame_oe && $fell(frame_l_out) |-> req_l)
    else $error("request still low at frame start");
  a_master_cmd_ok: assert property (
    frame_oe && $fell(frame_l_out) |-> cbe_oe && cbe_l_out inside {4'h6, 4'h7, 4'hC})
    else $error("illegal initiator command");
  // Data phases of our own reads carry all lanes enabled
  a_master_be_full: assert property (
    irdy_oe && !irdy_l_out |-> cbe_oe && cbe_l_out == 4'h0)
    else $error("byte enables not all on");
  a_irdy_last_drop: assert property (
    irdy_oe && !irdy_l_out && frame_l_out && !trdy_l_in |=> irdy_l_out)
    else $error("ready held after last phase");
  // Target side: claim two edges after the address edge, never for bad codes
  a_devsel_timing: assert property (
    !frame_oe && $fell(frame_l_in) && (cbe_l_in inside {4'h2, 4'h3, 4'h6, 4'h7, 4'hC, 4'hE, 4'hF}
      || (idsel && cbe_l_in inside {4'hA, 4'hB})) |-> ##2 (devsel_oe && !devsel_l_out))
    else $error("claim not two edges after address");
  a_no_bad_claim: assert property (
    !frame_oe && $fell(frame_l_in) && (cbe_l_in inside {4'h0, 4'h1, 4'h4, 4'h5, 4'h8,
      4'h9, 4'hD} || (!idsel && cbe_l_in inside {4'hA, 4'hB}))
      |=> (!devsel_oe || devsel_l_out) [*4])
    else $error("claimed an unsupported access");
  // Read data only after one idle turnaround cycle
  a_read_turnaround: assert property (
    devsel_oe && $fell(devsel_l_out) && trdy_l_out |-> !ad_oe ##1 (!trdy_l_out && ad_oe))
    else $error("read data timing wrong");
endmodule

bind host_bus_port host_bus_port_sva u_sva
(
  .clk_sys(clk_sys), .reset(reset), .ad_oe(ad_oe), .cbe_l_in(cbe_l_in),
  .cbe_l_out(cbe_l_out), .cbe_oe(cbe_oe), .frame_l_in(frame_l_in), .frame_l_out(frame_l_out),
  .frame_oe(frame_oe), .irdy_l_out(irdy_l_out), .irdy_oe(irdy_oe), .trdy_l_in(trdy_l_in),
  .trdy_l_out(trdy_l_out), .devsel_l_out(devsel_l_out), .devsel_oe(devsel_oe),
  .idsel(idsel), .req_l(req_l), .gnt_l(gnt_l)
);

//--- test/mem_partner.sv
`timescale 1ns/1ps
// Arbiter plus memory target serving the port's own read bursts
module mem_partner
(
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        slow,
  input  wire logic        drop_gnt,
  input  wire logic        req_l,
  input  wire logic        frame_w,
  input  wire logic        irdy_w,
  input  wire logic [31:0] ad_w,
  input  wire logic [3:0]  cbe_w,
  output logic             gnt_l,
  output logic             m_trdy,
  output logic             m_devsel,
  output logic             m_oe,
  output logic      [31:0] m_ad,
  output logic      [3:0]  cmd_seen
);
  logic [31:0] base;
  logic [7:0]  k;
  logic [7:0]  cnt;
  logic        act;
  logic        fr_q;

  // Each word simply carries its own byte address
  assign m_ad = base + {22'h0, k, 2'h0};

  // Grant after two request cycles; optionally yanked once, which a
  // lazy initiator would miss
  always_ff @(posedge clk_sys)
  begin
    fr_q  <= frame_w;
    cnt   <= (reset || req_l) ? 8'h00 : cnt + 8'h01;
    gnt_l <= reset || req_l || cnt < 8'h02 || (drop_gnt && cnt == 8'h03);
    if (reset)
    begin
      act      <= 1'b0;
      m_trdy   <= 1'b1;
      m_devsel <= 1'b1;
      m_oe     <= 1'b0;
    end
    else if (!act)
    begin
      // Upper half of the address space only, so host cycles pass by
      if (!frame_w && fr_q && ad_w[31])
      begin
        act      <= 1'b1;
        base     <= ad_w;
        cmd_seen <= cbe_w;
        k        <= 8'h00;
        m_devsel <= 1'b0;
      end
    end
    else if (!irdy_w && !m_trdy)
    begin
      k      <= k + 8'h01;
      m_trdy <= frame_w || slow;
      if (frame_w)
      begin
        act      <= 1'b0;
        m_devsel <= 1'b1;
        m_oe     <= 1'b0;
      end
    end
    else
    begin
      m_trdy <= 1'b0;
      m_oe   <= 1'b1;
    end
  end
endmodule

//--- test/tb.sv
`timescale 1ns/1ps
module tb;
  logic        clk_sys, reset, idsel, rd_start, rd_ready, slow, drop_gnt, rd_busy, rd_valid;
  logic        h_frame, h_irdy, h_adoe, h_cbeon, m_trdy, m_devsel, m_oe, parity_err;
  logic        ad_oe, cbe_oe, par_out, par_oe, frame_l_out, frame_oe, irdy_l_out, irdy_oe;
  logic        trdy_l_out, trdy_oe, devsel_l_out, devsel_oe, stop_l_out, stop_oe, req_l;
  logic        gnt_l, frame_w, irdy_w, trdy_w, devsel_w, stop_w, par_in, hit, stp;
  logic [31:0] h_ad, rd_addr, ad_w, ad_out, rd_data, m_ad, rd;
  logic [3:0]  h_cbe, cbe_w, cbe_l_out, cmd_seen;
  logic [7:0]  rd_words;
  logic [31:0] ad_q;
  logic [3:0]  cbe_q;
  int          bad_count = 0;
  int          n_compared = 0;

  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // Bus wires: pulled-up controls; an undriven AD or lane bus flips each cycle
  assign ad_w     = ad_oe ? ad_out : m_oe ? m_ad : h_adoe ? h_ad : ~ad_q;
  assign cbe_w    = cbe_oe ? cbe_l_out : h_cbeon ? h_cbe : ~cbe_q;
  assign frame_w  = (frame_oe ? frame_l_out : 1'b1) & h_frame;
  assign irdy_w   = (irdy_oe ? irdy_l_out : 1'b1) & h_irdy;
  assign trdy_w   = (trdy_oe ? trdy_l_out : 1'b1) & m_trdy;
  assign devsel_w = (devsel_oe ? devsel_l_out : 1'b1) & m_devsel;
  assign stop_w   = stop_oe ? stop_l_out : 1'b1;
  assign par_in   = par_oe ? par_out : ^{ad_q, cbe_q};
  always_ff @(posedge clk_sys)
  begin
    ad_q  <= reset ? 32'h0 : ad_w;
    cbe_q <= reset ? 4'h0 : cbe_w;
  end

  host_bus_port #(.FIFO_DEPTH(4), .CSR_WORDS(32)) dut
  (
    .clk_sys(clk_sys), .reset(reset), .ad_in(ad_w), .ad_out(ad_out), .ad_oe(ad_oe),
    .cbe_l_in(cbe_w), .cbe_l_out(cbe_l_out), .cbe_oe(cbe_oe), .par_in(par_in),
    .par_out(par_out), .par_oe(par_oe), .frame_l_in(frame_w), .frame_l_out(frame_l_out),
    .frame_oe(frame_oe), .irdy_l_in(irdy_w), .irdy_l_out(irdy_l_out), .irdy_oe(irdy_oe),
    .trdy_l_in(trdy_w), .trdy_l_out(trdy_l_out), .trdy_oe(trdy_oe), .devsel_l_in(devsel_w),
    .devsel_l_out(devsel_l_out), .devsel_oe(devsel_oe), .stop_l_out(stop_l_out),
    .stop_oe(stop_oe), .idsel(idsel), .req_l(req_l), .gnt_l(gnt_l), .rd_start(rd_start),
    .rd_addr(rd_addr), .rd_words(rd_words), .rd_busy(rd_busy), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .rd_data(rd_data), .parity_err(parity_err)
  );
  mem_partner u_mem
  (
    .clk_sys(clk_sys), .reset(reset), .slow(slow), .drop_gnt(drop_gnt), .req_l(req_l),
    .frame_w(frame_w), .irdy_w(irdy_w), .ad_w(ad_w), .cbe_w(cbe_w), .gnt_l(gnt_l),
    .m_trdy(m_trdy), .m_devsel(m_devsel), .m_oe(m_oe), .m_ad(m_ad), .cmd_seen(cmd_seen)
  );

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    if (bad_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Parity must match the lines of the cycle before; no false alarms
  always @(negedge clk_sys)
    if (!reset)
    begin
      if (par_oe)
        check("parity", {31'h0, ^{ad_q, cbe_q}}, {31'h0, par_out});
      check("parity_err", 32'h0, {31'h0, parity_err});
    end

  // One host access, single phase or a two-phase burst
  task automatic host_cycle(input logic [3:0] cmd, input logic [3:0] be,
    input logic [31:0] addr, input logic [31:0] wd, input logic burst, input logic sel);
    int t;
    t = 0;
    hit = 1'b0;
    @(negedge clk_sys);
    h_frame = 1'b0;
    h_adoe = 1'b1;
    h_cbeon = 1'b1;
    h_ad = addr;
    h_cbe = cmd;
    idsel = sel;
    @(negedge clk_sys);
    h_frame = !burst;
    h_irdy = 1'b0;
    h_adoe = cmd[0];
    h_ad = wd;
    h_cbe = be;
    idsel = 1'b0;
    while (trdy_w !== 1'b0 && t < 8)
    begin
      hit = hit | (devsel_w === 1'b0);
      @(negedge clk_sys);
      t++;
    end
    hit = hit | (devsel_w === 1'b0);
    rd = ad_w;
    if (hit && t >= 8)
    begin
      check("wait bound", 32'h0, 32'h1);
      give_verdict();
    end
    @(negedge clk_sys);
    for (t = 0; burst && stop_w !== 1'b0 && t < 4; t++)
      @(negedge clk_sys);
    stp = (stop_w === 1'b0);
    h_frame = 1'b1;
    if (burst)
      @(negedge clk_sys);
    h_irdy = 1'b1;
    h_adoe = 1'b0;
    h_cbeon = 1'b0;
  endtask

  task automatic t_config();
    logic [31:0] a;
    for (int i = 0; i < 2; i++)
    begin
      a = i ? 32'h0000_00FC : 32'h0000_0040;
      host_cycle(4'hB, 4'h0, a, 32'h5A00_0000 | a, 1'b0, 1'b1);
      check("cfg claim", 32'h1, {31'h0, hit});
      host_cycle(4'hA, 4'h0, a, 32'h0, 1'b0, 1'b1);
      check("cfg data", 32'h5A00_0000 | a, rd);
    end
  endtask

  task automatic t_commands();
    logic [3:0] ok_cmd [7] = '{4'h2, 4'h3, 4'h6, 4'h7, 4'hC, 4'hE, 4'hF};
    logic [3:0] no_cmd [8] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9, 4'hD, 4'hA};
    foreach (ok_cmd[i])
    begin
      host_cycle(ok_cmd[i], 4'hF, 32'h0000_0010, 32'h0, 1'b0, 1'b0);
      check("claim", 32'h1, {31'h0, hit});
      check("blank data", 32'h0, rd);
    end
    foreach (no_cmd[i])
    begin
      host_cycle(no_cmd[i], 4'h0, 32'h0000_0010, 32'h0, 1'b0, 1'b0);
      check("no claim", 32'h0, {31'h0, hit});
    end
  endtask

  // Mode word: reset value, masked write ignored, blank read
  task automatic t_mode();
    host_cycle(4'h2, 4'h0, 32'h0, 32'h0, 1'b0, 1'b0);
    check("mode reset", 32'h0, rd);
    host_cycle(4'h3, 4'h0, 32'h0, 32'h0020_0000, 1'b0, 1'b0);
    host_cycle(4'h3, 4'hF, 32'h0, 32'hFFFF_FFFF, 1'b0, 1'b0);
    host_cycle(4'h2, 4'h0, 32'h0, 32'h0, 1'b0, 1'b0);
    check("mode", 32'h0020_0000, rd);
    host_cycle(4'h2, 4'hF, 32'h0, 32'h0, 1'b0, 1'b0);
    check("masked read", 32'h0, rd);
    host_cycle(4'h2, 4'h0, 32'h0, 32'h0, 1'b1, 1'b0);
    check("burst data", 32'h0020_0000, rd);
    check("retry", 32'h1, {31'h0, stp});
  endtask

  // Own read burst; the drain stalls first so a burst of four words or more fills the buffer
  task automatic t_master(input logic [7:0] n, input logic [3:0] cmd, input logic s,
    input logic d);
    int got;
    int t;
    got = 0;
    t = 0;
    @(negedge clk_sys);
    slow = s;
    drop_gnt = d;
    rd_addr = 32'h8000_0100;
    rd_words = n;
    rd_start = 1'b1;
    @(negedge clk_sys);
    rd_start = 1'b0;
    while ((got < n || rd_busy !== 1'b0) && t < 400)
    begin
      rd_ready = (t > 12) && t[0];
      if (rd_valid === 1'b1 && rd_ready)
      begin
        check("read word", 32'h8000_0100 + 32'(4 * got), rd_data);
        got++;
      end
      @(negedge clk_sys);
      t++;
    end
    rd_ready = 1'b0;
    check("words", 32'(n), 32'(got));
    check("command", {28'h0, cmd}, {28'h0, cmd_seen});
    if (t >= 400)
    begin
      check("master bound", 32'h0, 32'h1);
      give_verdict();
    end
  endtask

  initial
  begin
    reset = 1'b1;
    {idsel, rd_start, rd_ready, slow, drop_gnt, h_adoe, h_cbeon} = 7'h00;
    {h_frame, h_irdy} = 2'h3;
    h_ad = 32'h0;
    h_cbe = 4'h0;
    rd_addr = 32'h0;
    rd_words = 8'h01;
    repeat (6) @(negedge clk_sys);
    reset = 1'b0;
    t_config();
    t_commands();
    t_master(8'h06, 4'h6, 1'b0, 1'b0);
    t_mode();
    t_master(8'h01, 4'h6, 1'b1, 1'b0);
    t_master(8'h05, 4'hC, 1'b1, 1'b1);
    give_verdict();
  end
endmodule
